/* core/olrg_pkg.sv */
// constants, field positions and state codes for the octal gated register
// assumes a single 40 MHz core clock and pins sampled into that clock

package olrg_pkg;

    // ---------------------------------------------------------------
    // widths
    // ---------------------------------------------------------------
    localparam int OLRG_WORD_W = 8;
    localparam int OLRG_GATE_N = 3;
    localparam int OLRG_CLK_PERIOD_NS = 25;

    // ---------------------------------------------------------------
    // positions inside the synchronised pin vector
    // ---------------------------------------------------------------
    localparam int OLRG_POS_DATA = 0;
    localparam int OLRG_POS_EDGE = 8;
    localparam int OLRG_POS_LOAD = 9;
    localparam int OLRG_POS_ZERO = 10;
    localparam int OLRG_POS_GATE = 11;
    localparam int OLRG_PIN_W = 14;

    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    // edge high, load closed, clear active, all three drive gates closed
    localparam logic [OLRG_PIN_W-1:0] OLRG_PIN_RST = 14'h3b00;
    localparam logic OLRG_EDGE_RST = 1'h1;
    localparam logic [OLRG_WORD_W-1:0] OLRG_ZERO_WORD = 8'h00;
    localparam logic [OLRG_GATE_N-1:0] OLRG_GATES_OPEN = 3'h0;

    // ---------------------------------------------------------------
    // function of the last cycle
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        OLRG_ST_CLEAR = 3'b001,
        OLRG_ST_HOLD = 3'b010,
        OLRG_ST_LOAD = 3'b100
    } olrg_state_t;

endpackage

/* core/olrg_core_if.sv */
// signals between the pin synchroniser, the storage word and the core
// assumes all three modules run on the same clock and reset

`timescale 1ns/100ps

interface olrg_core_if;
    import olrg_pkg::*;

    logic [OLRG_WORD_W-1:0] data;
    logic edge_lvl;
    logic load_n;
    logic zero_n;
    logic [OLRG_GATE_N-1:0] gates_n;
    logic load;
    logic clear;
    logic [OLRG_WORD_W-1:0] word;

    modport syncer (output data, edge_lvl, load_n, zero_n, gates_n);
    modport store (input load, clear, data, output word);
    modport core (input data, edge_lvl, load_n, zero_n, gates_n, word, output load, clear);

endinterface

/* core/olrg_pin_sync.sv */
// three-stage synchroniser for every pin of the register
// assumes pins are asynchronous to clock_i; a change counts once stages 2 and 3 agree

`timescale 1ns/100ps

module olrg_pin_sync
    import olrg_pkg::*;
#(
    parameter int W = OLRG_PIN_W,
    parameter logic [W-1:0] RST = OLRG_PIN_RST
) (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic [W-1:0] pins_i,
    olrg_core_if.syncer bus
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] stable;
    } olrg_sync_t;

    olrg_sync_t r;
    olrg_sync_t next_r;
    logic [W-1:0] agree;

    // ---------------------------------------------------------------
    // stages
    // ---------------------------------------------------------------
    // s1 feeds only s2; agreement filters a late metastable settle
    always_comb begin
        next_r = r;
        agree = ~(r.s2 ^ r.s3);
        next_r.s1 = pins_i;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        next_r.stable = (agree & r.s3) | (~agree & r.stable);
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            r <= {RST, RST, RST, RST};
        end else begin
            r <= next_r;
        end
    end

    assign bus.data = r.stable[OLRG_POS_DATA +: OLRG_WORD_W];
    assign bus.edge_lvl = r.stable[OLRG_POS_EDGE];
    assign bus.load_n = r.stable[OLRG_POS_LOAD];
    assign bus.zero_n = r.stable[OLRG_POS_ZERO];
    assign bus.gates_n = r.stable[OLRG_POS_GATE +: OLRG_GATE_N];

endmodule

/* core/olrg_store.sv */
// the stored word: one storage bit per data line
// assumes load and clear come from the core on the same clock

`timescale 1ns/100ps

module olrg_store
    import olrg_pkg::*;
#(
    parameter int WIDTH = OLRG_WORD_W
) (
    input wire logic clock_i,
    input wire logic rstn_i,
    olrg_core_if.store bus
);

    typedef struct packed {
        logic [WIDTH-1:0] word;
    } olrg_store_t;

    olrg_store_t r;
    olrg_store_t next_r;
    logic [WIDTH-1:0] next_bit;

    // ---------------------------------------------------------------
    // storage bits
    // ---------------------------------------------------------------
    for (genvar b = 0; b < WIDTH; b++) begin : g_bit
        // clear before load, else hold
        assign next_bit[b] = bus.clear ? 1'b0 : (bus.load ? bus.data[b] : r.word[b]); // RULE_01

        property p_bit_load;
            @(posedge clock_i) disable iff (!rstn_i)
            (bus.load && !bus.clear) |=> (r.word[b] == $past(bus.data[b]));
        endproperty
        a_bit_load: assert property (p_bit_load) // RULE_01
            else $error("storage bit missed its own data line");
    end

    always_comb begin
        next_r = r;
        next_r.word = next_bit;
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign bus.word = r.word;

endmodule

/* core/olrg_octal_reg.sv */
// top of the octal register with clear, load gate and three drive gates
// assumes every pin is asynchronous to clock_i and held several cycles;
// the pin clock is sampled, so its edges must be well below clock_i / 8

`timescale 1ns/100ps

// Contract
// (RULE_01) eight separate storage bits, own data line
// (RULE_02) bits capture data on rising pin clock
// (RULE_03) clock and drive gating shared by bits
// (RULE_04) all drive gates low: drive stored word
// (RULE_05) any drive gate high: outputs float
// (RULE_06) drive gates never alter stored word
// (RULE_07) clear low forces word to zero
// (RULE_08) load only while clear high; clear wins
// (RULE_09) load gate low: capture data on edge
// (RULE_10) load gate high: word holds unchanged
// (RULE_11) outputs equal stored bits, not inverted
module olrg_octal_reg
    import olrg_pkg::*;
(
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic [OLRG_WORD_W-1:0] parallel_in_bits_i,
    input wire logic sample_edge_in_i,
    input wire logic load_gate_n_i,
    input wire logic zero_force_n_i,
    input wire logic [OLRG_GATE_N-1:0] drive_gates_n_i,
    output logic [OLRG_WORD_W-1:0] parallel_out_bits_o,
    output logic [OLRG_WORD_W-1:0] parallel_out_oe_o
);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        logic prev_edge;
        olrg_state_t state;
        logic [OLRG_WORD_W-1:0] out_word;
        logic [OLRG_WORD_W-1:0] out_oe;
    } olrg_core_t;

    olrg_core_t r;
    olrg_core_t next_r;
    logic rise;
    logic gates_open;
    logic [OLRG_PIN_W-1:0] pins;

    olrg_core_if bus ();

    // ---------------------------------------------------------------
    // pin synchroniser and storage
    // ---------------------------------------------------------------
    // every pin takes the same path, so data, gates and edge stay aligned
    assign pins = {drive_gates_n_i, zero_force_n_i, load_gate_n_i,
                   sample_edge_in_i, parallel_in_bits_i};

    olrg_pin_sync #(
        .W(OLRG_PIN_W),
        .RST(OLRG_PIN_RST)
    ) u_sync (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .pins_i(pins),
        .bus(bus.syncer)
    );

    olrg_store #(
        .WIDTH(OLRG_WORD_W)
    ) u_store (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .bus(bus.store)
    );

    // ---------------------------------------------------------------
    // load and clear strobes
    // ---------------------------------------------------------------
    // one edge detector serves all eight bits
    assign rise = bus.edge_lvl & ~r.prev_edge; // RULE_03
    // clear is seen after the synchroniser, so it is not instant at the pins
    assign bus.clear = ~bus.zero_n; // RULE_07
    // drive gates take no part in loading
    assign bus.load = rise & bus.zero_n & ~bus.load_n; // RULE_08 RULE_06
    assign gates_open = (bus.gates_n == OLRG_GATES_OPEN);

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.prev_edge = bus.edge_lvl; // RULE_02
        case (r.state)
            OLRG_ST_CLEAR: begin
                if (bus.clear) begin
                    next_r.state = OLRG_ST_CLEAR;
                end else if (bus.load) begin
                    next_r.state = OLRG_ST_LOAD;
                end else begin
                    next_r.state = OLRG_ST_HOLD;
                end
            end
            OLRG_ST_HOLD, OLRG_ST_LOAD: begin
                if (bus.clear) begin
                    next_r.state = OLRG_ST_CLEAR;
                end else if (bus.load) begin
                    next_r.state = OLRG_ST_LOAD; // RULE_09
                end else begin
                    next_r.state = OLRG_ST_HOLD; // RULE_10
                end
            end
            default: begin
                next_r.state = OLRG_ST_CLEAR;
            end
        endcase
        // data flop always follows the word; only the enable floats it
        next_r.out_word = bus.word; // RULE_11
        next_r.out_oe = gates_open ? '1 : '0; // RULE_04
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            r.prev_edge <= OLRG_EDGE_RST;
            r.state <= OLRG_ST_CLEAR;
            r.out_word <= OLRG_ZERO_WORD;
            r.out_oe <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign parallel_out_bits_o = r.out_word;
    assign parallel_out_oe_o = r.out_oe; // RULE_05

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rstn_i);

    sequence s_load_seen;
        bus.load ##1 1'b1;
    endsequence

    sequence s_zero_path;
        (bus.word == OLRG_ZERO_WORD) ##1 (r.out_word == OLRG_ZERO_WORD);
    endsequence

    sequence s_clear_then_open;
        bus.clear ##1 gates_open;
    endsequence

    sequence s_float_then_open;
        (|bus.gates_n) ##1 gates_open;
    endsequence

    sequence s_clear_twice;
        bus.clear ##1 bus.clear;
    endsequence

    property p_load;
        bus.load |=> (bus.word == $past(bus.data));
    endproperty
    a_load: assert property (p_load) // RULE_09
        else $error("load did not store the data lines");

    property p_no_edge;
        (bus.zero_n && !rise) |=> $stable(bus.word);
    endproperty
    a_no_edge: assert property (p_no_edge) // RULE_02
        else $error("word changed without a rising pin clock");

    property p_hold;
        (bus.zero_n && bus.load_n) |=> (bus.word == $past(bus.word));
    endproperty
    a_hold: assert property (p_hold) // RULE_10
        else $error("word changed while load gate closed");

    property p_clear;
        bus.clear |=> s_zero_path;
    endproperty
    a_clear: assert property (p_clear) // RULE_07
        else $error("clear did not zero word and output");

    property p_clear_wins;
        (bus.clear && rise && !bus.load_n) |=> (bus.word == OLRG_ZERO_WORD);
    endproperty
    a_clear_wins: assert property (p_clear_wins) // RULE_08
        else $error("load beat an active clear");

    property p_clear_no_load;
        bus.clear |-> !bus.load;
    endproperty
    a_clear_no_load: assert property (p_clear_no_load) // RULE_08
        else $error("load strobe while clear active");

    property p_drive;
        gates_open |=> ((&r.out_oe) && (r.out_word == $past(bus.word)));
    endproperty
    a_drive: assert property (p_drive) // RULE_04
        else $error("open gates did not drive the word");

    property p_cleared_drive;
        s_clear_then_open |=> (r.out_word == OLRG_ZERO_WORD) && (&r.out_oe);
    endproperty
    a_cleared_drive: assert property (p_cleared_drive) // RULE_07
        else $error("cleared word not driven low");

    property p_float;
        (|bus.gates_n) |=> (r.out_oe == '0);
    endproperty
    a_float: assert property (p_float) // RULE_05
        else $error("output driven with a gate closed");

    property p_shared_oe;
        (r.out_oe == '0) || (&r.out_oe);
    endproperty
    a_shared_oe: assert property (p_shared_oe) // RULE_03
        else $error("enables differ between bits");

    property p_float_load;
        (bus.load && (|bus.gates_n)) |=> (bus.word == $past(bus.data));
    endproperty
    a_float_load: assert property (p_float_load) // RULE_06
        else $error("floating outputs blocked a load");

    property p_gates_quiet;
        ($changed(bus.gates_n) && bus.zero_n && !bus.load) |=> $stable(bus.word);
    endproperty
    a_gates_quiet: assert property (p_gates_quiet) // RULE_06
        else $error("drive gate change altered the word");

    property p_out_follows;
        s_load_seen |=> (r.out_word == $past(bus.data, 2));
    endproperty
    a_out_follows: assert property (p_out_follows) // RULE_11
        else $error("output not equal to loaded data");

    property p_state_load;
        (r.state == OLRG_ST_LOAD) |-> $past(bus.load);
    endproperty
    a_state_load: assert property (p_state_load) // RULE_09
        else $error("load state without a load");

    property p_load_needs_rise;
        bus.load |-> rise;
    endproperty
    a_load_needs_rise: assert property (p_load_needs_rise) // RULE_02
        else $error("load strobe without a rising pin clock");

    property p_gate_blocks_load;
        bus.load_n |-> !bus.load;
    endproperty
    a_gate_blocks_load: assert property (p_gate_blocks_load) // RULE_10
        else $error("load strobe with load gate closed");

    // the detector must track the level every cycle, or a slow rise counts twice
    property p_prev_edge;
        1'b1 |=> (r.prev_edge == $past(bus.edge_lvl));
    endproperty
    a_prev_edge: assert property (p_prev_edge) // RULE_02
        else $error("edge detector lost the pin clock level");

    property p_single_rise;
        rise |=> !rise;
    endproperty
    a_single_rise: assert property (p_single_rise) // RULE_02
        else $error("one pin clock rise gave two strobes");

    // state is observation only; these tie it to the strobes
    property p_state_clear;
        bus.clear |=> (r.state == OLRG_ST_CLEAR);
    endproperty
    a_state_clear: assert property (p_state_clear) // RULE_07
        else $error("clear not reflected in state");

    property p_state_hold;
        (!bus.clear && !bus.load) |=> (r.state == OLRG_ST_HOLD);
    endproperty
    a_state_hold: assert property (p_state_hold) // RULE_10
        else $error("hold not reflected in state");

    property p_load_state;
        bus.load |=> (r.state == OLRG_ST_LOAD);
    endproperty
    a_load_state: assert property (p_load_state) // RULE_09
        else $error("load not reflected in state");

    property p_no_invert;
        1'b1 |=> (r.out_word == $past(bus.word));
    endproperty
    a_no_invert: assert property (p_no_invert) // RULE_11
        else $error("output word differs from stored word");

    property p_reopen;
        s_float_then_open |=> ((&r.out_oe) && (r.out_word == $past(bus.word)));
    endproperty
    a_reopen: assert property (p_reopen) // RULE_04
        else $error("reopened gates did not drive the word");

    property p_oe_only_gates;
        $stable(bus.gates_n) |=> $stable(r.out_oe);
    endproperty
    a_oe_only_gates: assert property (p_oe_only_gates) // RULE_05
        else $error("enable moved with the drive gates still");

    property p_clear_holds;
        s_clear_twice |-> (bus.word == OLRG_ZERO_WORD);
    endproperty
    a_clear_holds: assert property (p_clear_holds) // RULE_07
        else $error("word not zero under a standing clear");

    property p_clear_floats;
        (bus.clear && !gates_open) |=> (r.out_oe == '0);
    endproperty
    a_clear_floats: assert property (p_clear_floats) // RULE_05
        else $error("cleared word driven with a gate closed");

endmodule

/* verification/olrg_bus_src.sv */
// upstream bus logic model driving the register pins
// assumes the bench calls drive() from one process only

`timescale 1ns/100ps

module olrg_bus_src
    import olrg_pkg::*;
(
    input wire logic clock_i,
    output logic [OLRG_WORD_W-1:0] data_o,
    output logic edge_o,
    output logic load_n_o,
    output logic zero_n_o,
    output logic [OLRG_GATE_N-1:0] gates_n_o
);
    // ---------------------------------------------------------------
    // idle levels
    // ---------------------------------------------------------------
    // pin clock starts low so release of reset gives no load
    initial begin
        data_o = 8'h00;
        edge_o = 1'b0;
        load_n_o = 1'b1;
        zero_n_o = 1'b1;
        gates_n_o = 3'h7;
    end

    // ---------------------------------------------------------------
    // one pin clock cycle
    // ---------------------------------------------------------------
    // controls settle 5 core cycles before the rise, held through the fall,
    // since every pin goes through the same sampling path
    task automatic drive(input logic [7:0] d, input logic ld_n, input logic zr_n,
                         input logic [2:0] g);
        @(posedge clock_i);
        #1;
        data_o = d;
        load_n_o = ld_n;
        zero_n_o = zr_n;
        gates_n_o = g;
        repeat (5) @(posedge clock_i);
        #1;
        edge_o = 1'b1;
        repeat (4) @(posedge clock_i);
        #1;
        edge_o = 1'b0;
        repeat (7) @(posedge clock_i);
        #1;
    endtask
endmodule

/* verification/test_octal_register_clear_load_gate.sv */
// self-checking bench for the octal gated register
// assumes the partner model drives all pins; outputs resolved to z here

`timescale 1ns/100ps

module test_octal_register_clear_load_gate;
    import olrg_pkg::*;

    logic clock_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [7:0] data;
    logic edge_lvl;
    logic load_n;
    logic zero_n;
    logic [2:0] gates_n;
    logic [7:0] out_bits;
    logic [7:0] out_oe;
    wire [7:0] bus_w;
    logic [7:0] exp_q[$];
    logic [7:0] word_m = 8'h00;
    int errors = 0;
    int cmp_count = 0;
    event seen;

    initial begin
        forever #(OLRG_CLK_PERIOD_NS / 2.0) clock_i = ~clock_i;
    end

    // ---------------------------------------------------------------
    // design, partner, resolved bus
    // ---------------------------------------------------------------
    olrg_octal_reg i_olrg_octal_reg (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .parallel_in_bits_i(data),
        .sample_edge_in_i(edge_lvl),
        .load_gate_n_i(load_n),
        .zero_force_n_i(zero_n),
        .drive_gates_n_i(gates_n),
        .parallel_out_bits_o(out_bits),
        .parallel_out_oe_o(out_oe)
    );

    olrg_bus_src i_olrg_bus_src (
        .clock_i(clock_i),
        .data_o(data),
        .edge_o(edge_lvl),
        .load_n_o(load_n),
        .zero_n_o(zero_n),
        .gates_n_o(gates_n)
    );

    for (genvar i = 0; i < 8; i++) begin : g_res
        assign bus_w[i] = out_oe[i] ? out_bits[i] : 1'bz;
    end

    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic check_bus(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // expectation noted from the function table, then the watcher compares
    task automatic op(input logic [7:0] d, input logic ld_n, input logic zr_n,
                      input logic [2:0] g);
        if (!zr_n) begin
            word_m = 8'h00;
        end else if (!ld_n) begin
            word_m = d;
        end
        i_olrg_bus_src.drive(d, ld_n, zr_n, g);
        exp_q.push_back((g == 3'h0) ? word_m : 8'hzz);
        ->seen;
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------
    // watcher
    // ---------------------------------------------------------------
    always @(seen) begin
        check_bus(bus_w, exp_q.pop_front());
    end

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        void'($urandom(32'hc1ec));
        repeat (10) @(posedge clock_i);
        #1;
        rstn_i = 1'b1;
        op(8'hff, 1'b0, 1'b1, 3'h0);
        for (int i = 0; i < 8; i++) begin
            op(8'h01 << i, 1'b0, 1'b1, 3'h0);
        end
        repeat (6) op(8'($urandom()), 1'b0, 1'b1, 3'h0);
        // every nonzero gate pattern floats the bus; load still lands behind it
        for (int g = 1; g < 8; g++) begin
            op(8'($urandom()), 1'b0, 1'b1, 3'(g));
            op(8'($urandom()), 1'b1, 1'b1, 3'h0);
        end
        op(~word_m, 1'b1, 1'b1, 3'h0);
        op(8'h5a, 1'b0, 1'b0, 3'h0);
        op(8'ha5, 1'b0, 1'b1, 3'h2);
        op(8'h3c, 1'b0, 1'b0, 3'h4);
        op(8'hc3, 1'b1, 1'b1, 3'h0);
        final_report();
    end

    // ---------------------------------------------------------------
    // watchdog
    // ---------------------------------------------------------------
    // 34 ops of 17 cycles each; generous margin
    initial begin
        #(OLRG_CLK_PERIOD_NS * 5000);
        errors++;
        final_report();
    end
endmodule
